// ---- narrow_ext_mem_if_control_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module narrow_ext_mem_if_control_tb
  import nemc_pkg::*;
;
  typedef struct packed {
    logic [31:0] a;
    logic        w;
    logic        b;
    logic        p;
    logic [2:0]  ctrl;
    logic [11:0] cfg;
    logic [11:0] exp;
  } nemc_row_s;
  localparam nemc_row_s ROWS [12] = '{
    '{32'h8000_0000, 1'b0, 1'b0, 1'b0, 3'h0, 12'h090, 12'h0f8},
    '{32'h8400_0001, 1'b1, 1'b1, 1'b0, 3'h0, 12'h090, 12'h144},
    '{32'h8400_0000, 1'b1, 1'b1, 1'b0, 3'h0, 12'h090, 12'h124},
    '{32'h8800_0000, 1'b1, 1'b0, 1'b0, 3'h0, 12'h090, 12'h27c},
    '{32'h8800_0000, 1'b0, 1'b0, 1'b0, 3'h0, 12'h090, 12'h278},
    '{32'h8c00_0000, 1'b0, 1'b0, 1'b0, 3'h0, 12'h090, 12'h47a},
    '{32'h8c00_0000, 1'b1, 1'b0, 1'b0, 3'h0, 12'h090, 12'h474},
    '{32'h8c00_0000, 1'b1, 1'b0, 1'b0, 3'h0, 12'h890, 12'h464},
    '{32'h8000_0000, 1'b1, 1'b0, 1'b0, 3'h4, 12'h090, 12'h0a4},
    '{32'h8000_0000, 1'b1, 1'b0, 1'b1, 3'h0, 12'h090, 12'h0e5},
    '{32'h0000_0000, 1'b0, 1'b0, 1'b0, 3'h0, 12'h090, 12'h800},
    '{32'h9000_0000, 1'b1, 1'b0, 1'b0, 3'h0, 12'h090, 12'h800}};
  localparam int ST_FULL [4] = '{8, 4, 6, 8};
  localparam int ST_DIV [4] = '{8, 8, 24, 32};
  logic        CLK_I, RESETN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, REQ_READY_O, DONE_O;
  logic        REQ_VALID_I, REQ_WRITE_I, REQ_BYTE_I, REQ_PDT_I, IF_CLK_IN_I, HOLD_REQ_IN_I;
  logic        DONE_ERR_O, IF_CLK_OUT_FULL_O, IF_CLK_OUT_DIV_O, BL0_N, BL1_N, RD_N, OE_N, WE_N;
  logic        FIFO_N, PDT_N, CTRL_OE_N_O, ASYNC_READY_IN_I, HOLD_GRANT_O, BUS_REQ_OUT_O;
  logic [31:0] AWADDR_I, WDATA_I, ARADDR_I, RDATA_O, REQ_ADDR_I;
  logic [3:0]  WSTRB_I, SP_N, mem_wait;
  logic [1:0]  BRESP_O, RRESP_O, CLK_SELECT_STRAPS_I, ext_cnt, resp;
  logic [10:0] pins_vec;
  logic [11:0] seen;
  logic [31:0] rd;
  int          err_count, checks_done, cf, cs, pf, pd;
  assign pins_vec = {SP_N, BL1_N, BL0_N, RD_N, OE_N, WE_N, FIFO_N, PDT_N};
  nemc_top u_dut (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .REQ_VALID_I(REQ_VALID_I),
    .REQ_READY_O(REQ_READY_O), .REQ_ADDR_I(REQ_ADDR_I), .REQ_WRITE_I(REQ_WRITE_I),
    .REQ_BYTE_I(REQ_BYTE_I), .REQ_PDT_I(REQ_PDT_I), .DONE_O(DONE_O), .DONE_ERR_O(DONE_ERR_O),
    .CLK_SELECT_STRAPS_I(CLK_SELECT_STRAPS_I), .IF_CLK_IN_I(IF_CLK_IN_I),
    .IF_CLK_OUT_FULL_O(IF_CLK_OUT_FULL_O), .IF_CLK_OUT_DIV_O(IF_CLK_OUT_DIV_O),
    .MEM_SPACE_ENABLE_N_O(SP_N), .BYTE_LANE0_ENABLE_N_O(BL0_N), .BYTE_LANE1_ENABLE_N_O(BL1_N),
    .RD_CAS_ADSTRB_PIN_N_O(RD_N), .OE_RAS_PIN_N_O(OE_N), .WR_ENABLE_PIN_N_O(WE_N),
    .FIFO_SPACE_OUT_ENABLE_N_O(FIFO_N), .PERIPH_DIRECT_XFER_N_O(PDT_N), .CTRL_OE_N_O(CTRL_OE_N_O),
    .ASYNC_READY_IN_I(ASYNC_READY_IN_I), .HOLD_REQ_IN_I(HOLD_REQ_IN_I),
    .HOLD_GRANT_O(HOLD_GRANT_O), .BUS_REQ_OUT_O(BUS_REQ_OUT_O));
  nemc_mem_model u_mem (.clk_i(CLK_I), .resetn_i(RESETN_I), .rd_n_i(RD_N), .wr_n_i(WE_N),
    .space_n_i(SP_N), .wait_i(mem_wait), .ready_o(ASYNC_READY_IN_I));
  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end
  // External interface clock, period 8 cycles
  always @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ext_cnt     <= 2'h0;
      IF_CLK_IN_I <= 1'b0;
    end else begin
      ext_cnt <= ext_cnt + 2'h1;
      if (ext_cnt == 2'h3) IF_CLK_IN_I <= ~IF_CLK_IN_I;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic rst(input logic [1:0] s);
    @(posedge CLK_I);
    CLK_SELECT_STRAPS_I <= s;
    RESETN_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    RESETN_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
  endtask
  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, ha, hw;
    ta = 1'b0;
    tw = 1'b0;
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge CLK_I);
      ha = AWVALID_I && AWREADY_O;
      hw = WVALID_I && WREADY_O;
      @(posedge CLK_I);
      if (ha) begin
        ta = 1'b1;
        AWVALID_I <= 1'b0;
      end
      if (hw) begin
        tw = 1'b1;
        WVALID_I <= 1'b0;
      end
    end
    do begin
      @(negedge CLK_I);
      ha = BVALID_O;
      r = BRESP_O;
      @(posedge CLK_I);
    end while (ha !== 1'b1);
    BREADY_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    do begin
      @(negedge CLK_I);
      h = ARREADY_O;
      @(posedge CLK_I);
    end while (h !== 1'b1);
    ARVALID_I <= 1'b0;
    do begin
      @(negedge CLK_I);
      h = RVALID_O;
      d = RDATA_O;
      r = RRESP_O;
      @(posedge CLK_I);
    end while (h !== 1'b1);
    RREADY_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic core(input nemc_row_s t, output logic [11:0] sn, output int cyc);
    logic [10:0] lo;
    logic        dn, er;
    lo = 11'h0;
    cyc = 0;
    er = 1'b0;
    @(posedge CLK_I);
    REQ_ADDR_I <= t.a;
    REQ_WRITE_I <= t.w;
    REQ_BYTE_I <= t.b;
    REQ_PDT_I <= t.p;
    REQ_VALID_I <= 1'b1;
    do begin
      @(negedge CLK_I);
      dn = REQ_READY_O;
      @(posedge CLK_I);
    end while (dn !== 1'b1);
    REQ_VALID_I <= 1'b0;
    dn = 1'b0;
    while (!dn) begin
      @(negedge CLK_I);
      cyc++;
      lo = lo | ~pins_vec;
      dn = (DONE_O === 1'b1);
      er = dn && (DONE_ERR_O === 1'b1);
    end
    repeat (2) @(negedge CLK_I) lo = lo | ~pins_vec;
    sn = {er, lo};
  endtask
  task automatic period(input logic sel, output int p);
    logic prev, cur;
    int   k, r1;
    prev = 1'b1;
    r1 = -1;
    p = 0;
    for (k = 0; k < 300 && p == 0; k++) begin
      @(negedge CLK_I);
      cur = sel ? IF_CLK_OUT_DIV_O : IF_CLK_OUT_FULL_O;
      if (cur === 1'b1 && prev === 1'b0) begin
        if (r1 >= 0) p = k - r1;
        r1 = k;
      end
      prev = cur;
    end
  endtask
  initial begin
    #(40 * 20000);
    err_count++;
    wrap_up();
  end
  initial begin
    {RESETN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, REQ_VALID_I} <= 7'h0;
    {REQ_WRITE_I, REQ_BYTE_I, REQ_PDT_I, HOLD_REQ_IN_I} <= 4'h0;
    {AWADDR_I, WDATA_I, ARADDR_I, REQ_ADDR_I} <= 128'h0;
    WSTRB_I <= 4'hf;
    CLK_SELECT_STRAPS_I <= 2'h0;
    mem_wait <= 4'h0;
    err_count = 0;
    checks_done = 0;
    for (int i = 0; i < 4; i++) begin
      rst(2'(i));
      `CHK(pins_vec, PINS_IDLE)
      axr({28'h0, OFS_CTRL}, rd, resp);
      `CHK(rd, 32'h0)
      axw({28'h0, OFS_CTRL}, 32'(i), resp);
      axr({28'h0, OFS_STATUS}, rd, resp);
      `CHK(rd[1:0], (i == 3) ? STRAP_EXT : 2'(i))
      period(1'b0, pf);
      period(1'b1, pd);
      `CHK(pf, ST_FULL[i])
      `CHK(pd, ST_DIV[i])
      $display("clock test %0d done", i);
    end
    rst(STRAP_DIV4);
    for (int i = 0; i < 12; i++) begin
      axw({28'h0, OFS_CTRL}, 32'(ROWS[i].ctrl), resp);
      axw({28'h0, OFS_SPACE_CFG}, 32'(ROWS[i].cfg), resp);
      core(ROWS[i], seen, cf);
      `CHK(seen, ROWS[i].exp)
      $display("access test %0d done", i);
    end
    axr({28'h0, OFS_SPACE_CFG}, rd, resp);
    `CHK(rd, 32'h090)
    axr(32'hc, rd, resp);
    `CHK({rd, resp}, {32'h0, RESP_SLVERR})
    axw({28'h0, OFS_STATUS}, 32'h0, resp);
    `CHK(resp, RESP_SLVERR)
    $display("register test done");
    core(ROWS[0], seen, cf);
    mem_wait <= 4'ha;
    core(ROWS[0], seen, cs);
    `CHK(seen, ROWS[0].exp)
    `CHK(cs > cf + 4, 1'b1)
    mem_wait <= 4'h0;
    $display("ready test done");
    @(posedge CLK_I);
    HOLD_REQ_IN_I <= 1'b1;
    REQ_VALID_I <= 1'b1;
    @(posedge CLK_I);
    @(negedge CLK_I);
    `CHK({HOLD_GRANT_O, CTRL_OE_N_O, REQ_READY_O}, 3'b110)
    `CHK(BUS_REQ_OUT_O, 1'b1)
    @(posedge CLK_I);
    HOLD_REQ_IN_I <= 1'b0;
    core(ROWS[0], seen, cs);
    `CHK(seen, ROWS[0].exp)
    `CHK({HOLD_GRANT_O, CTRL_OE_N_O, BUS_REQ_OUT_O}, 3'b000)
    $display("hold test done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- nemc_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module nemc_mem_model
  import nemc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [3:0] space_n_i,
  input  wire logic [3:0] wait_i,
  output logic            ready_o
);
  logic [3:0] cnt_reg;
  logic       strobe;
  assign strobe = !rd_n_i || !wr_n_i;
  // Cycles spent in the current strobe
  always_ff @(posedge clk_i) begin
    if (!resetn_i || !strobe) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'hf) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // Busy for wait_i cycles, pulled up when not selected
  assign ready_o = (&space_n_i) || !strobe || (cnt_reg >= wait_i);
endmodule
`default_nettype wire

// ---- nemc_pkg.sv ----
package nemc_pkg;

  // Register byte offsets
  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_SPACE_CFG = 4'h4;
  localparam logic [3:0]  OFS_STATUS    = 4'h8;

  // Reset values
  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam logic [11:0] SPACE_CFG_RST = 12'h000;

  // Field positions
  localparam int          CTRL_DIV_LSB   = 0;
  localparam int          CTRL_WIDTH8    = 2;
  localparam int          CFG_RDSEL_LSB  = 8;

  // Space decode on address bits 31:26
  localparam logic [5:0]  SPACE_BASE = 6'h20;

  // Clock strap codes
  localparam logic [1:0]  STRAP_EXT  = 2'h0;
  localparam logic [1:0]  STRAP_DIV4 = 2'h1;
  localparam logic [1:0]  STRAP_DIV6 = 2'h2;

  // Output clock 2 divide codes
  localparam logic [1:0]  DIV_BY1 = 2'h0;
  localparam logic [1:0]  DIV_BY2 = 2'h1;

  // Divider cycle counts
  localparam logic [2:0]  CNT_DIV4 = 3'h4;
  localparam logic [2:0]  CNT_DIV6 = 3'h6;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MT_ASYNC = 2'h0,
    MT_SDRAM = 2'h1,
    MT_PSYNC = 2'h2
  } nemc_mtype_e;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETUP  = 5'b00010,
    ST_STROBE = 5'b00100,
    ST_HOLD   = 5'b01000,
    ST_GRANT  = 5'b10000
  } nemc_state_e;

  // Memory-side control pins, all active low
  typedef struct packed {
    logic [3:0] space_en_n;
    logic [1:0] lane_en_n;
    logic       rd_cas_n;
    logic       oe_ras_n;
    logic       wr_en_n;
    logic       fifo_oe_n;
    logic       pdt_n;
  } nemc_pins_s;

  localparam nemc_pins_s PINS_IDLE = 11'h7ff;

endpackage

// ---- nemc_top.sv ----
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Memory space chosen by decoding word-address bits 26 to 31.
// - Exactly one of four space enables asserted during an external access.
// - Byte enables decoded from low address bits, depending on memory width.
// - Byte enables act as write enables and as SDRAM data masks.
// - Interface clock: external pin, CPU/4 or CPU/6, strapped at reset.
// - External clock pin is the default interface clock.
// - Strap 00 external, 01 CPU/4, 10 CPU/6, 11 reserved.
// - Second output clock is interface clock divided by 1, 2 or 4.
// - First output clock runs at interface clock frequency.
// - Read pin: async read, SDRAM CAS, sync address strobe or read.
// - Sync read select 0 gives address strobe, 1 gives read enable.
// - Output-enable pin: async OE, SDRAM RAS or sync OE.
// - Write pin: async, SDRAM or sync write enable by memory type.
// - Dedicated sync output enable for space 3 FIFO.
// - Peripheral transfer strobe for direct peripheral to peripheral moves.
// - Host raises hold request; device answers with hold grant.
// - Bus request output shows external accesses pending.
module nemc_top
  import nemc_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic [31:0] AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [31:0] ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  input  wire logic        REQ_VALID_I,
  output logic             REQ_READY_O,
  input  wire logic [31:0] REQ_ADDR_I,
  input  wire logic        REQ_WRITE_I,
  input  wire logic        REQ_BYTE_I,
  input  wire logic        REQ_PDT_I,
  output logic             DONE_O,
  output logic             DONE_ERR_O,
  input  wire logic [1:0]  CLK_SELECT_STRAPS_I,
  input  wire logic        IF_CLK_IN_I,
  output logic             IF_CLK_OUT_FULL_O,
  output logic             IF_CLK_OUT_DIV_O,
  output logic [3:0]       MEM_SPACE_ENABLE_N_O,
  output logic             BYTE_LANE0_ENABLE_N_O,
  output logic             BYTE_LANE1_ENABLE_N_O,
  output logic             RD_CAS_ADSTRB_PIN_N_O,
  output logic             OE_RAS_PIN_N_O,
  output logic             WR_ENABLE_PIN_N_O,
  output logic             FIFO_SPACE_OUT_ENABLE_N_O,
  output logic             PERIPH_DIRECT_XFER_N_O,
  output logic             CTRL_OE_N_O,
  input  wire logic        ASYNC_READY_IN_I,
  input  wire logic        HOLD_REQ_IN_I,
  output logic             HOLD_GRANT_O,
  output logic             BUS_REQ_OUT_O
);

  logic [2:0]  ctrl_reg;
  logic [11:0] space_cfg_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [3:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wr_fire;
  logic [3:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;

  logic [1:0]  strap_reg;
  logic        strap_taken_reg;
  logic        ext_clk_d_reg;
  logic [2:0]  div_cnt_reg;
  logic [2:0]  div_period;
  logic        if_tick;
  logic        clk_full_reg;
  logic        clk_div_reg;
  logic        tick_cnt_reg;

  nemc_state_e state_reg;
  nemc_state_e state_next;
  logic [1:0]  space_reg;
  logic        err_reg;
  logic        write_reg;
  logic        byte_reg;
  logic        addr0_reg;
  logic        pdt_reg;
  nemc_mtype_e mtype_reg;
  logic        rdsel_reg;
  logic        width8_reg;
  nemc_pins_s  pins_reg;
  nemc_pins_s  pins_next;
  logic        done_reg;
  logic        done_err_reg;
  logic        accept;
  logic [5:0]  space_code;
  logic        in_access;

  // AXI4-Lite write channel
  assign AWREADY_O = !aw_held_reg;
  assign WREADY_O  = !w_held_reg;
  assign wr_fire   = (aw_held_reg || AWVALID_I) && (w_held_reg || WVALID_I) && !bvalid_reg;
  assign wr_addr   = aw_held_reg ? aw_addr_reg : AWADDR_I[3:0];
  assign wr_data   = w_held_reg ? w_data_reg : WDATA_I;
  assign wr_strb   = w_held_reg ? w_strb_reg : WSTRB_I;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wr_addr == OFS_CTRL || wr_addr == OFS_SPACE_CFG) ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (AWVALID_I && !aw_held_reg) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= AWADDR_I[3:0];
        end
        if (WVALID_I && !w_held_reg) begin
          w_held_reg <= 1'b1;
          w_data_reg <= WDATA_I;
          w_strb_reg <= WSTRB_I;
        end
        if (bvalid_reg && BREADY_I) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  // Configuration registers
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ctrl_reg      <= CTRL_RST;
      space_cfg_reg <= SPACE_CFG_RST;
    end else if (wr_fire) begin
      if (wr_addr == OFS_CTRL && wr_strb[0]) begin
        ctrl_reg <= wr_data[2:0];
      end
      if (wr_addr == OFS_SPACE_CFG && wr_strb[0]) begin
        space_cfg_reg[7:0] <= wr_data[7:0];
      end
      if (wr_addr == OFS_SPACE_CFG && wr_strb[1]) begin
        space_cfg_reg[11:8] <= wr_data[11:8];
      end
    end
  end

  // AXI4-Lite read channel
  assign ARREADY_O = !rvalid_reg;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end else if (ARVALID_I && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      case (ARADDR_I[3:0])
        OFS_CTRL:      rdata_reg <= {29'h0, ctrl_reg};
        OFS_SPACE_CFG: rdata_reg <= {20'h0, space_cfg_reg};
        OFS_STATUS:    rdata_reg <= {25'h0, space_reg, BUS_REQ_OUT_O, HOLD_GRANT_O, in_access, strap_reg};
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign BVALID_O = bvalid_reg;
  assign BRESP_O  = bresp_reg;
  assign RVALID_O = rvalid_reg;
  assign RDATA_O  = rdata_reg;
  assign RRESP_O  = rresp_reg;

  // Strap capture after reset release
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      strap_reg       <= STRAP_EXT;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_reg       <= (CLK_SELECT_STRAPS_I == STRAP_DIV4 || CLK_SELECT_STRAPS_I == STRAP_DIV6) ?
                         CLK_SELECT_STRAPS_I : STRAP_EXT;
    end
  end

  // Interface clock enable
  assign div_period = (strap_reg == STRAP_DIV6) ? CNT_DIV6 : CNT_DIV4;
  assign if_tick    = (strap_reg == STRAP_EXT) ? (IF_CLK_IN_I && !ext_clk_d_reg) :
                      (div_cnt_reg == 3'h0);

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ext_clk_d_reg <= 1'b0;
      div_cnt_reg   <= 3'h0;
    end else begin
      ext_clk_d_reg <= IF_CLK_IN_I;
      div_cnt_reg   <= (div_cnt_reg == div_period - 3'h1) ? 3'h0 : div_cnt_reg + 3'h1;
    end
  end

  // Output clocks
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      clk_full_reg <= 1'b0;
      clk_div_reg  <= 1'b0;
      tick_cnt_reg <= 1'b0;
    end else begin
      clk_full_reg <= (strap_reg == STRAP_EXT) ? IF_CLK_IN_I :
                      (div_cnt_reg < {1'b0, div_period[2:1]});
      if (if_tick) begin
        tick_cnt_reg <= !tick_cnt_reg;
      end
      if (ctrl_reg[CTRL_DIV_LSB +: 2] == DIV_BY1) begin
        clk_div_reg <= (strap_reg == STRAP_EXT) ? IF_CLK_IN_I : (div_cnt_reg < {1'b0, div_period[2:1]});
      end else if (if_tick && (ctrl_reg[CTRL_DIV_LSB +: 2] == DIV_BY2 || tick_cnt_reg)) begin
        clk_div_reg <= !clk_div_reg;
      end
    end
  end

  assign IF_CLK_OUT_FULL_O = clk_full_reg;
  assign IF_CLK_OUT_DIV_O  = clk_div_reg;

  // Access sequencer
  assign space_code  = REQ_ADDR_I[31:26] - SPACE_BASE;
  assign REQ_READY_O = (state_reg == ST_IDLE) && !HOLD_REQ_IN_I;
  assign accept      = REQ_VALID_I && REQ_READY_O;
  assign in_access   = (state_reg == ST_SETUP) || (state_reg == ST_STROBE) || (state_reg == ST_HOLD);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (HOLD_REQ_IN_I) begin
          state_next = ST_GRANT;
        end else if (accept && space_code[5:2] == 4'h0) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP:  state_next = if_tick ? ST_STROBE : ST_SETUP;
      ST_STROBE: begin
        if (if_tick && (mtype_reg != MT_ASYNC || ASYNC_READY_IN_I)) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD:   state_next = if_tick ? ST_IDLE : ST_HOLD;
      ST_GRANT:  state_next = HOLD_REQ_IN_I ? ST_GRANT : ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      space_reg  <= 2'h0;
      write_reg  <= 1'b0;
      byte_reg   <= 1'b0;
      addr0_reg  <= 1'b0;
      pdt_reg    <= 1'b0;
      mtype_reg  <= MT_ASYNC;
      rdsel_reg  <= 1'b0;
      width8_reg <= 1'b0;
      err_reg    <= 1'b0;
    end else if (accept) begin
      space_reg  <= space_code[1:0];
      err_reg    <= space_code[5:2] != 4'h0;
      write_reg  <= REQ_WRITE_I;
      byte_reg   <= REQ_BYTE_I;
      addr0_reg  <= REQ_ADDR_I[0];
      pdt_reg    <= REQ_PDT_I;
      mtype_reg  <= (space_cfg_reg[space_code[1:0]*2 +: 2] == 2'h3) ? MT_ASYNC :
                    nemc_mtype_e'(space_cfg_reg[space_code[1:0]*2 +: 2]);
      rdsel_reg  <= space_cfg_reg[CFG_RDSEL_LSB + space_code[1:0]];
      width8_reg <= ctrl_reg[CTRL_WIDTH8];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      done_reg     <= 1'b0;
      done_err_reg <= 1'b0;
    end else begin
      done_reg     <= (state_reg == ST_HOLD && if_tick) || (accept && space_code[5:2] != 4'h0);
      done_err_reg <= accept && space_code[5:2] != 4'h0;
    end
  end

  assign DONE_O     = done_reg;
  assign DONE_ERR_O = done_err_reg;

  // Pin decode per memory type
  always_comb begin
    pins_next = PINS_IDLE;
    if (in_access) begin
      pins_next.space_en_n = ~(4'h1 << space_reg);
      pins_next.pdt_n      = !pdt_reg;
      if (width8_reg) begin
        pins_next.lane_en_n = 2'b10;
      end else if (byte_reg) begin
        pins_next.lane_en_n = addr0_reg ? 2'b01 : 2'b10;
      end else begin
        pins_next.lane_en_n = 2'b00;
      end
      case (mtype_reg)
        MT_SDRAM: begin
          pins_next.oe_ras_n = !(state_reg == ST_SETUP);
          pins_next.rd_cas_n = !(state_reg == ST_STROBE);
          pins_next.wr_en_n  = !(state_reg == ST_STROBE && write_reg);
        end
        MT_PSYNC: begin
          pins_next.rd_cas_n  = rdsel_reg ? !(state_reg == ST_STROBE && !write_reg) :
                                !(state_reg == ST_SETUP);
          pins_next.oe_ras_n  = !(state_reg == ST_STROBE && !write_reg);
          pins_next.wr_en_n   = !(state_reg == ST_STROBE && write_reg);
          pins_next.fifo_oe_n = !(state_reg == ST_STROBE && !write_reg && space_reg == 2'h3);
        end
        default: begin
          pins_next.rd_cas_n = !(state_reg == ST_STROBE && !write_reg);
          pins_next.oe_ras_n = write_reg;
          pins_next.wr_en_n  = !(state_reg == ST_STROBE && write_reg);
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      pins_reg <= PINS_IDLE;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign MEM_SPACE_ENABLE_N_O      = pins_reg.space_en_n;
  assign BYTE_LANE0_ENABLE_N_O     = pins_reg.lane_en_n[0];
  assign BYTE_LANE1_ENABLE_N_O     = pins_reg.lane_en_n[1];
  assign RD_CAS_ADSTRB_PIN_N_O     = pins_reg.rd_cas_n;
  assign OE_RAS_PIN_N_O            = pins_reg.oe_ras_n;
  assign WR_ENABLE_PIN_N_O         = pins_reg.wr_en_n;
  assign FIFO_SPACE_OUT_ENABLE_N_O = pins_reg.fifo_oe_n;
  assign PERIPH_DIRECT_XFER_N_O    = pins_reg.pdt_n;
  assign HOLD_GRANT_O              = (state_reg == ST_GRANT);
  assign CTRL_OE_N_O               = (state_reg == ST_GRANT);
  assign BUS_REQ_OUT_O             = REQ_VALID_I || in_access;

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_div4_period;
    if_tick ##1 !if_tick [*3] ##1 if_tick;
  endsequence

  sequence s_strobe_wait;
    (state_reg == ST_STROBE) && mtype_reg == MT_ASYNC && !ASYNC_READY_IN_I;
  endsequence

  AST_ONE_SPACE: assert property (in_access |=> $onehot(~MEM_SPACE_ENABLE_N_O))
    else $error("space enables not one-hot during access");
  AST_SPACE_DECODE: assert property (accept && REQ_ADDR_I[31:26] == SPACE_BASE + 6'h2
    ##1 in_access |=> MEM_SPACE_ENABLE_N_O == 4'hb)
    else $error("wrong space enable for decoded address");
  AST_WIDTH8_LANE: assert property (in_access && width8_reg |=> BYTE_LANE1_ENABLE_N_O)
    else $error("upper byte lane used in 8-bit mode");
  AST_DIV4_TICK: assert property (strap_taken_reg && strap_reg == STRAP_DIV4 && div_cnt_reg == 3'h0
    |-> s_div4_period)
    else $error("CPU/4 interface clock period wrong");
  AST_DIV1_OUT: assert property (ctrl_reg[1:0] == DIV_BY1 ##1 ctrl_reg[1:0] == DIV_BY1
    |-> IF_CLK_OUT_DIV_O == IF_CLK_OUT_FULL_O)
    else $error("output clock 2 not undivided");
  AST_READY_EXTEND: assert property (s_strobe_wait |=> state_reg == ST_STROBE)
    else $error("async strobe ended while not ready");
  AST_GRANT_RELEASE: assert property (HOLD_REQ_IN_I && state_reg == ST_IDLE
    |=> HOLD_GRANT_O && CTRL_OE_N_O && !REQ_READY_O)
    else $error("hold not granted or outputs not released");
  AST_WRITE_ONLY_WE: assert property (!WR_ENABLE_PIN_N_O |-> $past(write_reg) && $past(in_access))
    else $error("write enable asserted on a read");
  AST_BUS_REQ: assert property (REQ_VALID_I |-> BUS_REQ_OUT_O)
    else $error("bus request missing while access pending");

endmodule

`default_nettype wire
